/* pbmtc_master.sv */
`include "pbmtc_defines.svh"

// Function
// (R1) Address busy asserted only after grant, no rerun, address bus idle.
// (R2) Address busy dropped the edge after address accept, for one clock.
// (R3) Address-bus busy also derived from transfer start and accept.
// (R4) Owner seeing rerun in window drops request, later restarts.
// (R5) Any rerun: drop request, refuse grant, no request for a while.
// (R6) Global snoop attribute driven from the image or channel setting.
// (R7) Cache inhibit attribute driven from the image or channel setting.
// (R8) System reruns by first transfer ack, held past address accept.
// (R9) One level of pipelining: new address while data tenure runs.
// (R10) Internal arbiter keeps request/grant inside, else external pins.
// (R11) Translated address from source, block size and offset; DMA untouched.
// (R12) Transfer kind from five-bit write and read fields.
// (R13) Four address parity bits, top byte on bit zero.
// (R14) Parity even or odd per the polarity control.
// (R15) Data bus requested by kind bit 3 high during transfer start; the code uses kind bit 1.
// (R16) Data busy only on grant, no rerun, data bus idle.
// (R17) Grant held past a tenure counts as a fresh grant.
// (R18) Slaves acknowledge no sooner than two clocks after start.
// (R19) Data busy dropped at least one clock after final ack.
// (R20) Data-bus busy also derived from bus control signals.
// (R21) Slave acks each eight-byte beat of a burst or a single beat.
module pbmtc_master
	import pbmtc_pkg::*;
#(
	parameter int ADDR_W = 32
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Transaction request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic        req_is_dma,
	input  wire logic        req_burst,
	input  wire logic [31:0] req_addr,
	input  wire logic [31:0] req_blk_mask,
	input  wire logic [31:0] req_xlat_offset,
	input  wire logic        translate_enable,
	input  wire logic [4:0]  write_xfer_kind,
	input  wire logic [4:0]  read_xfer_kind,
	input  wire logic        req_global,
	input  wire logic        req_cache_inh,
	// Configuration
	input  wire logic        parity_odd,
	input  wire logic        int_arb_en,
	// Internal arbiter
	output logic             int_bus_request,
	input  wire logic        int_bus_grant,
	// Completion
	output logic             addr_done,
	output logic             data_done,
	output logic             rerun_seen,
	// Arbitration pins
	output logic             ext_bus_request_n,
	input  wire logic        ext_bus_grant_n,
	input  wire logic        data_bus_grant_n,
	// Address tenure pins
	input  wire logic        addr_tenure_busy_i_n,
	output logic             addr_tenure_busy_o_n,
	output logic             addr_tenure_busy_oe_n,
	input  wire logic        xfer_start_i_n,
	output logic             xfer_start_o_n,
	output logic             xfer_start_oe_n,
	output logic [31:0]      addr_o,
	output logic [3:0]       addr_byte_parity,
	output logic [4:0]       transfer_kind,
	output logic             global_snoop_n,
	output logic             cache_inhibit_n,
	output logic             addr_oe_n,
	input  wire logic        addr_accept_n,
	input  wire logic        addr_rerun_n,
	// Data tenure pins
	input  wire logic        data_tenure_busy_i_n,
	output logic             data_tenure_busy_o_n,
	output logic             data_tenure_busy_oe_n,
	input  wire logic        xfer_ack_n,
	input  wire logic        beat_valid_n
);

	// Address path and parity are fixed at four bytes
	if (ADDR_W != 32)
	begin : g_bad_addr_w
		$error("pbmtc_master: address width must be 32");
	end

	pbmtc_astate_e astate_ff;
	pbmtc_dstate_e dstate_ff;
	logic [8:0]  meta_ff;
	logic [8:0]  sync_ff;
	logic [31:0] xaddr;
	logic [3:0]  xpar;
	logic [1:0]  hold_ff;
	logic [2:0]  cnt_ff;
	logic [2:0]  beats_ff;
	logic [1:0]  own_ts_ff;
	logic [1:0]  own_abb_ff;
	logic [1:0]  own_dbb_ff;
	logic        ts_ff;
	logic        dpend_ff;
	logic        fab_ff;
	logic        fdb_ff;
	logic        odd_ff;
	logic        ten;
	logic        dbusy;
	logic        grant_s;
	logic        dgrant_s;
	logic        aack_s;
	logic        rerun_s;
	logic        ack_s;
	logic        bval_s;
	logic        ts_s;
	logic        abb_s;
	logic        dbb_s;
	logic        ts_foreign;
	logic        abus_busy;
	logic        dbus_busy;
	logic        qual_ag;
	logic        qual_dg;
	logic        need_data;
	logic        want_req;
	logic        last_ack;

	// Pins cross from the bus clock tree; two stages each
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_ff <= 9'h1FF;
			sync_ff <= 9'h1FF;
		end
		else
		begin
			meta_ff <= {ext_bus_grant_n, data_bus_grant_n, addr_accept_n,
				addr_rerun_n, xfer_ack_n, beat_valid_n, xfer_start_i_n,
				addr_tenure_busy_i_n, data_tenure_busy_i_n};
			sync_ff <= meta_ff;
		end
	end

	assign grant_s  = ~sync_ff[8];
	assign dgrant_s = ~sync_ff[7];
	assign aack_s   = ~sync_ff[6];
	assign rerun_s  = ~sync_ff[5];
	assign ack_s    = ~sync_ff[4];
	assign bval_s   = ~sync_ff[3];
	assign ts_s     = ~sync_ff[2];
	assign abb_s    = ~sync_ff[1];
	assign dbb_s    = ~sync_ff[0];

	assign ten   = (astate_ff == A_TEN);
	assign dbusy = (dstate_ff == D_BUSY);

	// Own drive reads back two clocks late through the synchroniser
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			own_ts_ff  <= 2'h0;
			own_abb_ff <= 2'h0;
			own_dbb_ff <= 2'h0;
		end
		else
		begin
			own_ts_ff  <= {own_ts_ff[0], ts_ff};
			own_abb_ff <= {own_abb_ff[0], ten};
			own_dbb_ff <= {own_dbb_ff[0], dbusy};
		end
	end

	assign ts_foreign = ts_s && !own_ts_ff[1];

	// (R3) start-to-accept marks the address bus busy
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			fab_ff <= 1'b0;
		else if (ts_foreign)
			fab_ff <= 1'b1;
		else if (aack_s)
			fab_ff <= 1'b0;
	end

	// (R20) foreign start until a final ack marks data bus busy
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			fdb_ff <= 1'b0;
		else if (ts_foreign)
			fdb_ff <= 1'b1;
		else if ((ack_s && !bval_s && !dbusy) || rerun_s)
			fdb_ff <= 1'b0;
	end

	assign abus_busy = fab_ff || (abb_s && !own_abb_ff[1]);
	assign dbus_busy = fdb_ff || (dbb_s && !own_dbb_ff[1]);

	// (R5) hold-off after any rerun, owner or snooper
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			hold_ff <= 2'h0;
		else if (rerun_s)
			hold_ff <= `PBMTC_HOLD_CYC;
		else if (hold_ff != 2'h0)
			hold_ff <= hold_ff - 2'h1;
	end

	// (R10) grant source follows the arbiter selection
	// (R1) qualified address grant
	// (R5) a present grant is refused during rerun or hold-off
	assign qual_ag = (int_arb_en ? int_bus_grant : grant_s) && !rerun_s
		&& !abus_busy && (hold_ff == 2'h0);

	// (R9) a new address may start while a data tenure runs
	assign req_ready = (astate_ff == A_IDLE) && !dpend_ff;

	// (R4) restart after the rerun by requesting again
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			astate_ff <= A_IDLE;
		else
		begin
			case (astate_ff)
				A_IDLE:
					if (req_valid && req_ready)
						astate_ff <= A_REQ;
				A_REQ:
					if (qual_ag)
						astate_ff <= A_TEN;
				// (R8) early rerun beside a transfer ack aborts too
				A_TEN:
					if (rerun_s)
						astate_ff <= A_REQ;
					else if (aack_s)
						astate_ff <= A_WIN;
				A_WIN:
					if (rerun_s)
						astate_ff <= A_REQ;
					else
						astate_ff <= A_IDLE;
				default:
					astate_ff <= A_IDLE;
			endcase
		end
	end

	pbmtc_addr_gen u_addr_gen (
		.src_addr         (req_addr),
		.blk_mask         (req_blk_mask),
		.xlat_offset      (req_xlat_offset),
		.translate_enable (translate_enable),
		.is_dma           (req_is_dma),
		.parity_odd       (parity_odd),
		.bus_addr         (xaddr),
		.addr_byte_parity (xpar)
	);

	// Address-phase outputs captured when the request is taken
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_o           <= 32'h0;
			addr_byte_parity <= 4'h0;
			transfer_kind    <= `PBMTC_TT_RD_DEF;
			global_snoop_n   <= 1'b1;
			cache_inhibit_n  <= 1'b1;
			odd_ff           <= 1'b0;
			beats_ff         <= 3'h1;
		end
		else if (req_valid && req_ready)
		begin
			addr_o           <= xaddr;
			addr_byte_parity <= xpar;
			odd_ff           <= parity_odd;
			// (R12) write or read kind field
			transfer_kind    <= req_write ? write_xfer_kind : read_xfer_kind;
			// (R6) global snoop attribute
			global_snoop_n   <= ~req_global;
			// (R7) cache inhibit attribute
			cache_inhibit_n  <= ~req_cache_inh;
			// (R21) one ack per eight-byte beat
			beats_ff         <= req_burst ? `PBMTC_BURST_BEATS : 3'h1;
		end
	end

	// (R15) kind bit 1 carries the data bus request
	assign need_data = transfer_kind[`PBMTC_TT_DATA_BIT];

	// Start pulse on the first tenure clock only
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			ts_ff <= 1'b0;
		else
			ts_ff <= (astate_ff == A_REQ) && qual_ag;
	end

	// (R1) address busy driven only in the tenure
	// (R2) accept moves the tenure out; busy negated in window
	assign addr_tenure_busy_o_n  = ~ten;
	assign addr_tenure_busy_oe_n = ~ten;
	assign xfer_start_o_n        = ~ts_ff;
	assign xfer_start_oe_n       = ~ten;
	assign addr_oe_n             = ~ten;

	// (R5) no request during rerun or its hold-off
	// (R4) owner rerun in window drops the request
	assign want_req = (astate_ff == A_REQ) && !rerun_s && (hold_ff == 2'h0);

	// (R10) request routed to the internal or external arbiter
	assign int_bus_request   = want_req && int_arb_en;
	assign ext_bus_request_n = ~(want_req && !int_arb_en);

	assign addr_done  = (astate_ff == A_WIN) && !rerun_s;
	assign rerun_seen = ((astate_ff == A_WIN) || ten) && rerun_s;

	// Accepted address with data pending its tenure
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			dpend_ff <= 1'b0;
		else if (addr_done && need_data)
			dpend_ff <= 1'b1;
		else if ((dstate_ff == D_IDLE) && qual_dg)
			dpend_ff <= 1'b0;
	end

	// (R16) qualified data grant
	// (R17) a grant still high after a gap qualifies afresh
	assign qual_dg = dpend_ff && dgrant_s && !rerun_s && !dbus_busy;

	assign last_ack = dbusy && ack_s && (cnt_ff == 3'h1);

	// (R19) gap state forces one clock with data busy negated
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			dstate_ff <= D_IDLE;
		else
		begin
			case (dstate_ff)
				D_IDLE:
					if (qual_dg)
						dstate_ff <= D_BUSY;
				D_BUSY:
					if (last_ack || rerun_s)
						dstate_ff <= D_GAP;
				D_GAP:
					dstate_ff <= D_IDLE;
				default:
					dstate_ff <= D_IDLE;
			endcase
		end
	end

	// Beat count per tenure
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			cnt_ff <= 3'h0;
		else if ((dstate_ff == D_IDLE) && qual_dg)
			cnt_ff <= beats_ff;
		else if (dbusy && ack_s)
			cnt_ff <= cnt_ff - 3'h1;
	end

	assign data_tenure_busy_o_n  = ~dbusy;
	assign data_tenure_busy_oe_n = ~dbusy;
	assign data_done             = last_ack && !rerun_s;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence s_ack_in_ten;
		ten && aack_s;
	endsequence

	sequence s_last_beat;
		last_ack;
	endsequence

	property p_abb_qual;
		$rose(ten) |-> $past(qual_ag);
	endproperty
	a_abb_qual: assert property (p_abb_qual) else $error("busy without grant"); // (R1)

	property p_abb_drop;
		s_ack_in_ten |=> addr_tenure_busy_o_n ##1 (addr_tenure_busy_o_n || !rerun_s);
	endproperty
	a_abb_drop: assert property (p_abb_drop) else $error("busy kept after accept"); // (R2)

	property p_rtry_own;
		(astate_ff == A_WIN) && rerun_s |=> ext_bus_request_n && !int_bus_request;
	endproperty
	a_rtry_own: assert property (p_rtry_own) else $error("request after rerun"); // (R4)

	property p_snoop;
		rerun_s |=> !$rose(ten) [*2];
	endproperty
	a_snoop: assert property (p_snoop) else $error("grant taken after rerun"); // (R5)

	property p_par;
		!addr_oe_n |-> addr_byte_parity[0] == ((^addr_o[31:24]) ^ odd_ff);
	endproperty
	a_par: assert property (p_par) else $error("address parity wrong"); // (R13)

	property p_ts_tt3;
		!xfer_start_o_n && dpend_ff == 1'b0 && need_data |-> ##[1:300] addr_done || rerun_seen;
	endproperty
	a_ts_tt3: assert property (p_ts_tt3) else $error("data tenure lost"); // (R15)

	property p_dbb_qual;
		$rose(dbusy) |-> $past(dgrant_s && !rerun_s && !dbus_busy);
	endproperty
	a_dbb_qual: assert property (p_dbb_qual) else $error("data busy unqualified"); // (R16)

	property p_dbb_gap;
		s_last_beat |=> data_tenure_busy_o_n;
	endproperty
	a_dbb_gap: assert property (p_dbb_gap) else $error("no gap after final ack"); // (R19)

endmodule : pbmtc_master

/* pbmtc_defines.svh */
`ifndef PBMTC_DEFINES_SVH
`define PBMTC_DEFINES_SVH

// Transfer kind reset values
`define PBMTC_TT_WR_DEF   5'h02
`define PBMTC_TT_RD_DEF   5'h0A
// Position of the data-tenure bit in transfer_kind[4:0]
`define PBMTC_TT_DATA_BIT 1
// Beats of a burst data tenure
`define PBMTC_BURST_BEATS 3'h4
// Request hold-off after any address rerun
`define PBMTC_HOLD_CYC    2'h2

`endif

/* pbmtc_pkg.sv */
package pbmtc_pkg;

	typedef enum logic [1:0] {
		A_IDLE = 2'h0,
		A_REQ  = 2'h1,
		A_TEN  = 2'h2,
		A_WIN  = 2'h3
	} pbmtc_astate_e;

	typedef enum logic [1:0] {
		D_IDLE = 2'h0,
		D_BUSY = 2'h1,
		D_GAP  = 2'h2
	} pbmtc_dstate_e;

endpackage : pbmtc_pkg

/* pbmtc_addr_gen.sv */
module pbmtc_addr_gen
	import pbmtc_pkg::*;
(
	// Source address, translation and parity polarity
	input  wire logic [31:0] src_addr,
	input  wire logic [31:0] blk_mask,
	input  wire logic [31:0] xlat_offset,
	input  wire logic        translate_enable,
	input  wire logic        is_dma,
	input  wire logic        parity_odd,
	// Results
	output logic      [31:0] bus_addr,
	output logic      [3:0]  addr_byte_parity
);

	logic [31:0] sum;

	assign sum = src_addr + xlat_offset;

	// (R11) block-size offset translation
	// DMA destinations already carry their offset
	assign bus_addr = (translate_enable && !is_dma) ?
		((src_addr & blk_mask) | (sum & ~blk_mask)) : src_addr;

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_par
			// (R13) bit 0 covers the top byte
			// (R14) even or odd selection
			assign addr_byte_parity[i] = (^bus_addr[31-8*i -: 8]) ^ parity_odd;
		end
	endgenerate

endmodule : pbmtc_addr_gen

/* pbmtc_bus_model.sv */
module pbmtc_bus_model (
	// Clock and bench controls
	input  wire logic       clock,
	input  wire logic       rerun_req,
	input  wire logic [2:0] beats,
	// Master outputs and arbiter selection
	input  wire logic       int_arb_en,
	input  wire logic       int_bus_request,
	input  wire logic       ext_bus_request_n,
	input  wire logic       xfer_start_o_n,
	input  wire logic       data_tenure_busy_o_n,
	input  wire logic [4:0] transfer_kind,
	// Slave and arbiter answers
	output logic            int_bus_grant,
	output logic            ext_bus_grant_n,
	output logic            data_bus_grant_n,
	output logic            addr_accept_n,
	output logic            addr_rerun_n,
	output logic            xfer_ack_n,
	output logic            beat_valid_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int   q [$];
	int   n;
	int   m;
	logic rr;
	// Grant follows the selected request side
	initial
	begin
		{int_bus_grant, ext_bus_grant_n} = 2'h1;
		forever
		begin
			@(posedge clock);
			int_bus_grant <= int_arb_en & int_bus_request;
			ext_bus_grant_n <= int_arb_en | ext_bus_request_n;
		end
	end
	// Address slave; misses no start since tenures do not overlap
	initial
	begin
		{addr_accept_n, addr_rerun_n} = 2'h3;
		forever
		begin
			@(posedge clock);
			if (xfer_start_o_n === 1'b0)
			begin
				rr = rerun_req;
				n = beats;
				repeat (2) @(posedge clock);
				addr_accept_n <= 1'b0;
				@(posedge clock);
				addr_accept_n <= 1'b1;
				addr_rerun_n <= !rr;
				@(posedge clock);
				addr_rerun_n <= 1'b1;
				if (!rr && transfer_kind[1])
					q.push_back(n);
			end
		end
	end
	// Data slave; slow acks leave room for a pipelined start
	initial
	begin
		{data_bus_grant_n, xfer_ack_n, beat_valid_n} = 3'h7;
		forever
		begin
			@(posedge clock);
			if (q.size() > 0)
			begin
				m = q.pop_front();
				data_bus_grant_n <= 1'b0;
				// Let a running tenure end before waiting for the next
				while (data_tenure_busy_o_n === 1'b0)
					@(posedge clock);
				for (int i = 0; i < 50 && data_tenure_busy_o_n !== 1'b0; i++)
					@(posedge clock);
				for (int j = 0; j < m; j++)
				begin
					repeat (2) @(posedge clock);
					xfer_ack_n <= 1'b0;
					// grant held on while another tenure waits
					if (j == m - 1 && q.size() == 0)
						data_bus_grant_n <= 1'b1;
					@(posedge clock);
					xfer_ack_n <= 1'b1;
				end
			end
		end
	end
endmodule : pbmtc_bus_model

/* tb_proc_bus_master_tenure_ctrl.sv */
module tb_proc_bus_master_tenure_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic w, dma, bst, xl, arb, po, g, ci;
		logic [4:0] k;
		logic [31:0] a;
	} pbmtc_row_s;
	localparam logic [31:0] MASK = 32'hFFFF_0000;
	localparam logic [31:0] OFS = 32'h0001_2340;
	pbmtc_row_s rows [4] = '{
		'{1, 0, 1, 1, 0, 0, 1, 0, 5'h02, 32'h1234_5678},
		'{0, 0, 0, 1, 1, 1, 0, 1, 5'h02, 32'hA5A5_0001},
		'{1, 1, 0, 1, 0, 1, 1, 1, 5'h04, 32'h0F0F_F0F0},
		'{0, 0, 1, 0, 1, 0, 0, 0, 5'h0E, 32'hFFFF_FFFF}};
	logic clock, rstn, req_valid, req_write, req_is_dma, req_burst, translate_enable;
	logic req_global, req_cache_inh, parity_odd, int_arb_en, rerun_req, ovl;
	logic [31:0] req_addr, req_blk_mask, req_xlat_offset, addr_o;
	logic [4:0] write_xfer_kind, read_xfer_kind, transfer_kind;
	logic [3:0] addr_byte_parity;
	logic [2:0] beats;
	logic req_ready, int_bus_request, int_bus_grant, addr_done, data_done, rerun_seen;
	logic ext_bus_request_n, ext_bus_grant_n, data_bus_grant_n, addr_accept_n, addr_rerun_n;
	logic xfer_ack_n, beat_valid_n, global_snoop_n, cache_inhibit_n, addr_oe_n;
	logic addr_tenure_busy_o_n, addr_tenure_busy_oe_n, xfer_start_o_n, xfer_start_oe_n;
	logic data_tenure_busy_o_n, data_tenure_busy_oe_n;
	// Released shared lines rest at the pull-up level
	wire abb_w = addr_tenure_busy_oe_n | addr_tenure_busy_o_n;
	wire ts_w = xfer_start_oe_n | xfer_start_o_n;
	wire dbb_w = data_tenure_busy_oe_n | data_tenure_busy_o_n;
	int fails, checks_done, na, nd, nr, cyc, bad_arb, nd0;

	pbmtc_master pbmtc_master_i (
		.clock, .rstn, .req_valid, .req_ready, .req_write, .req_is_dma, .req_burst,
		.req_addr, .req_blk_mask, .req_xlat_offset, .translate_enable,
		.write_xfer_kind, .read_xfer_kind, .req_global, .req_cache_inh, .parity_odd,
		.int_arb_en, .int_bus_request, .int_bus_grant, .addr_done, .data_done, .rerun_seen,
		.ext_bus_request_n, .ext_bus_grant_n, .data_bus_grant_n,
		.addr_tenure_busy_i_n(abb_w), .addr_tenure_busy_o_n, .addr_tenure_busy_oe_n,
		.xfer_start_i_n(ts_w), .xfer_start_o_n, .xfer_start_oe_n, .addr_o, .addr_byte_parity,
		.transfer_kind, .global_snoop_n, .cache_inhibit_n, .addr_oe_n, .addr_accept_n,
		.addr_rerun_n, .data_tenure_busy_i_n(dbb_w), .data_tenure_busy_o_n,
		.data_tenure_busy_oe_n, .xfer_ack_n, .beat_valid_n);
	pbmtc_bus_model pbmtc_bus_model_i (
		.clock, .rerun_req, .beats, .int_arb_en, .int_bus_request, .ext_bus_request_n,
		.xfer_start_o_n, .data_tenure_busy_o_n, .transfer_kind, .int_bus_grant,
		.ext_bus_grant_n, .data_bus_grant_n, .addr_accept_n, .addr_rerun_n, .xfer_ack_n,
		.beat_valid_n);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clock)
	begin
		cyc++;
		na += int'(addr_done === 1'b1);
		nd += int'(data_done === 1'b1);
		nr += int'(rerun_seen === 1'b1);
		// request only on the selected side
		if (rstn && (int_arb_en ? ext_bus_request_n !== 1'b1 : int_bus_request !== 1'b0))
			bad_arb++;
		if (cyc == 20000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	function logic [31:0] xa(input pbmtc_row_s r);
		return (r.xl && !r.dma) ? (r.a & MASK) | ((r.a + OFS) & ~MASK) : r.a;
	endfunction : xa
	function logic [3:0] xp(input logic [31:0] a, input logic po);
		for (int i = 0; i < 4; i++)
			xp[i] = ^a[31 - 8 * i -: 8] ^ po;
	endfunction : xp
	task wt(input int s, input int n0);
		for (int i = 0; i < 300; i++)
		begin
			@(negedge clock);
			if ((s == 0 ? na : s == 1 ? nd : s == 2 ? nr : int'(xfer_start_o_n === 1'b0)) > n0)
				return;
		end
		chk("wait", 32'(s), 32'hFF);
	endtask : wt
	task look(input pbmtc_row_s r);
		ovl = data_tenure_busy_o_n === 1'b0;
		chk("addr", addr_o, xa(r));
		chk("parity", 32'(addr_byte_parity), 32'(xp(xa(r), r.po)));
		chk("kind", 32'(transfer_kind), 32'(r.w ? r.k : r.k ^ 5'h08));
		chk("global", 32'(global_snoop_n), 32'(!r.g));
		chk("inhibit", 32'(cache_inhibit_n), 32'(!r.ci));
		chk("abb", 32'(abb_w), 32'h0);
		chk("addr oe", 32'(addr_oe_n), 32'h0);
		chk("start oe", 32'(xfer_start_oe_n), 32'h0);
	endtask : look
	task go(input pbmtc_row_s r, input logic rr, input logic pipe);
		int a0, d0, r0;
		a0 = na;
		d0 = nd;
		r0 = nr;
		{req_write, req_is_dma, req_burst, translate_enable} = {r.w, r.dma, r.bst, r.xl};
		{int_arb_en, parity_odd, req_global, req_cache_inh} = {r.arb, r.po, r.g, r.ci};
		{req_addr, write_xfer_kind, read_xfer_kind} = {r.a, r.k, r.k ^ 5'h08};
		{rerun_req, beats, req_valid} = {rr, r.bst ? 3'h4 : 3'h1, 1'b1};
		for (int i = 0; i < 100 && req_ready !== 1'b1; i++)
			@(negedge clock);
		@(negedge clock);
		req_valid = 1'b0;
		wt(3, 0);
		look(r);
		if (rr)
		begin
			wt(2, r0);
			rerun_req = 1'b0;
			wt(3, 0);
			look(r);
		end
		wt(0, a0);
		if (!pipe && r.k[1])
			wt(1, d0);
	endtask : go
	initial
	begin
		{rstn, req_valid, req_write, req_is_dma, req_burst, translate_enable} = 6'h0;
		{req_global, req_cache_inh, parity_odd, int_arb_en, rerun_req} = 5'h0;
		{req_addr, req_blk_mask, req_xlat_offset} = {32'h0, MASK, OFS};
		{write_xfer_kind, read_xfer_kind, beats} = {5'h02, 5'h0A, 3'h1};
		repeat (6) @(negedge clock);
		chk("ready", 32'(req_ready), 32'h1);
		chk("kind", 32'(transfer_kind), 32'h0A);
		chk("abb oe", 32'(addr_tenure_busy_oe_n), 32'h1);
		chk("dbb oe", 32'(data_tenure_busy_oe_n), 32'h1);
		chk("request", 32'(ext_bus_request_n), 32'h1);
		repeat (6) @(negedge clock);
		rstn = 1'b1;
		foreach (rows[i])
			go(rows[i], 1'b0, 1'b0);
		go(rows[1], 1'b1, 1'b0);
		nd0 = nd;
		go(rows[0], 1'b0, 1'b1);
		go(rows[3], 1'b0, 1'b0);
		wt(1, nd0 + 1);
		chk("overlap", 32'(ovl), 32'h1);
		chk("arb side", 32'(bad_arb), 32'h0);
		report_and_stop();
	end
endmodule : tb_proc_bus_master_tenure_ctrl
